// ---- relay_ctrl.sv ----
// Purpose: Four-channel relay and LED controller with register port.
// Assumes: value is a signed measured or peak result, over_range flags range excess.
// Notes:   Remote commanded states clear on reset, standing for power loss.
// Functional notes
// - Each channel holds a signed first threshold, clamped to -999..9999.
// - Second signed threshold, same range, used only in two-threshold modes.
// - Hysteresis 0..999; dead band spans threshold plus and minus it.
// - Relay stays unchanged while input lies inside the dead band.
// - Inactive mode keeps relay off except forced-on fault reaction.
// - Energise-above mode: on above upper border, off below lower border.
// - De-energise-above mode: off above upper border, on below lower border.
// - Inside window: on between inner borders of lower and higher thresholds.
// - Outside window: on above higher upper border or below lower border.
// - Remote mode follows host-written state, input ignored, except while a link fault applies the fault reaction.
// - Indicator LED lights whenever the channel relay is closed.
// - Remote commanded state returns to default after reset.
// - Turn-on needs input beyond border for the whole turn-on delay.
// - Turn-off needs input beyond border for the whole turn-off delay.
// - Returning inside the band discards a partial delay count.
// - Delays count in tenths of a second or tenths of a minute, chosen per channel.
// - Fault reaction holds, forces on, or forces off on critical condition.
// - Threshold modes treat out-of-range input as critical.
// - Remote mode is critical when link silence exceeds the timeout limit.
// - Forced-on fault reaction energises even an inactive channel.
// - Each channel has its own full parameter set.
// - Zero delays switch at once when a border is crossed.
`timescale 1ns/1ps
`default_nettype none
module relay_ctrl
(
   // Clock and reset.
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   // Measurement side.
   input  wire logic signed [15:0]        value,
   input  wire logic                      over_range,
   // Remote link activity: one pulse per received frame.
   input  wire logic                      link_rx,
   // Register port.
   input  wire logic [5:0]                reg_addr,
   input  wire logic [15:0]               reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [15:0]               reg_rdata,
   // Relay drivers and LEDs.
   output logic      [relay_pkg::NUM_CH-1:0] relay_out,
   output logic      [relay_pkg::NUM_CH-1:0] led_out
);
   import relay_pkg::*;

   // Time base: tenth-second tick, then divide by sixty for tenth-minute.
   logic [23:0] pre_q;
   logic [5:0]  min_q;
   logic        tenth_sec;
   logic        tenth_min;
   wire  logic  pre_wrap = pre_q == 24'(TENTH_CYCLES - 1);
   wire  logic  min_wrap = min_q == MIN_PRESCALE;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         pre_q <= '0;
         min_q <= '0;
      end
      else
      begin
         pre_q <= pre_wrap ? 24'h000000 : pre_q + 24'h000001;
         if (pre_wrap)
            min_q <= min_wrap ? 6'h00 : min_q + 6'h01;
      end
   end

   assign tenth_sec = pre_wrap;
   assign tenth_min = pre_wrap && min_wrap;

   // Link silence timer in tenth-second ticks, restarted by each frame.
   logic [15:0] link_limit_q;
   logic [15:0] silence_q;
   logic        link_fault;
   wire  logic  link_seen = link_rx || (reg_wr && reg_addr == OFS_LINK_KICK);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         silence_q <= '0;
      else if (link_seen)
         silence_q <= '0;
      else if (tenth_sec && silence_q != 16'hffff)
         silence_q <= silence_q + 16'h0001;
   end

   assign link_fault = silence_q > link_limit_q;

   // Address decode.
   wire logic [1:0] ch_sel    = reg_addr[4:3];
   wire logic [2:0] ofs       = reg_addr[2:0];
   wire logic       ch_space  = reg_addr[5] == 1'b0;

   // Clamp helpers for written values.
   wire logic signed [15:0] wr_s    = reg_wdata;
   wire logic signed [15:0] thr_clamped = (wr_s < THR_MIN) ? THR_MIN :
                                          (wr_s > THR_MAX) ? THR_MAX : wr_s;
   wire logic        [15:0] hys_clamped = (reg_wdata > HYS_MAX) ? HYS_MAX : reg_wdata;
   wire logic        [9:0]  dly_clamped = (reg_wdata > 16'(DLY_MAX)) ? DLY_MAX : reg_wdata[9:0];

   // Per-channel storage, flip-flops indexed by channel.
   logic signed [15:0] thr1_q  [NUM_CH];
   logic signed [15:0] thr2_q  [NUM_CH];
   logic        [15:0] hys_q   [NUM_CH];
   logic        [6:0]  cfg_q   [NUM_CH];
   logic        [9:0]  ton_q   [NUM_CH];
   logic        [9:0]  deenergise_delay_q  [NUM_CH];
   logic               rem_q   [NUM_CH];
   logic        [NUM_CH-1:0] relay_w;
   logic        [NUM_CH-1:0] pend_w;

   // Register writes; each channel keeps its own set.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            thr1_q[i] <= RST_THR;
            thr2_q[i] <= RST_THR;
            hys_q[i]  <= RST_HYS;
            cfg_q[i]  <= '0;
            ton_q[i]  <= RST_DLY;
            deenergise_delay_q[i] <= RST_DLY;
            rem_q[i]  <= 1'b0;
         end
         link_limit_q <= RST_LINK_LIMIT;
      end
      else if (reg_wr && ch_space)
      begin
         unique case (ofs)
            OFS_THR1:   thr1_q[ch_sel] <= thr_clamped;
            OFS_THR2:   thr2_q[ch_sel] <= thr_clamped;
            OFS_HYS:    hys_q[ch_sel]  <= hys_clamped;
            OFS_CFG:    cfg_q[ch_sel]  <= reg_wdata[6:0];
            OFS_TON:    ton_q[ch_sel]  <= dly_clamped;
            OFS_DEENERGISE_DELAY:   deenergise_delay_q[ch_sel] <= dly_clamped;
            OFS_REMOTE: rem_q[ch_sel]  <= reg_wdata[0];
            OFS_STATUS: ;
         endcase
      end
      else if (reg_wr && reg_addr == OFS_LINK_LIMIT)
         link_limit_q <= reg_wdata;
   end

   // Read mux; unmapped addresses read zero.
   logic [15:0] rd_mux;
   always_comb
   begin
      rd_mux = '0;
      if (ch_space)
      begin
         unique case (ofs)
            OFS_THR1:   rd_mux = thr1_q[ch_sel];
            OFS_THR2:   rd_mux = thr2_q[ch_sel];
            OFS_HYS:    rd_mux = hys_q[ch_sel];
            OFS_CFG:    rd_mux = {9'h000, cfg_q[ch_sel]};
            OFS_TON:    rd_mux = {6'h00, ton_q[ch_sel]};
            OFS_DEENERGISE_DELAY:   rd_mux = {6'h00, deenergise_delay_q[ch_sel]};
            OFS_REMOTE: rd_mux = {15'h0000, rem_q[ch_sel]};
            OFS_STATUS: rd_mux = {12'h000, link_fault, over_range, pend_w[ch_sel], relay_w[ch_sel]};
         endcase
      end
      else if (reg_addr == OFS_LINK_LIMIT)
         rd_mux = link_limit_q;
      else if (reg_addr == OFS_LINK_KICK)
         rd_mux = silence_q;
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         reg_rdata <= '0;
      else
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
   end

   // Channel instances.
   for (genvar g = 0; g < NUM_CH; g++)
   begin : gen_ch
      chan_if ci ();
      mode_t           mode_w;
      fault_reaction_t fr_w;
      assign mode_w          = (cfg_q[g][2:0] > 3'(MODE_REMOTE)) ? MODE_INACTIVE : mode_t'(cfg_q[g][2:0]);
      assign fr_w            = (cfg_q[g][5:4] == 2'h3) ? FAULT_HOLD : fault_reaction_t'(cfg_q[g][5:4]);
      assign ci.thr1         = thr1_q[g];
      assign ci.thr2         = thr2_q[g];
      assign ci.hys          = hys_q[g];
      assign ci.mode         = mode_w;
      assign ci.unit_min     = cfg_q[g][CFG_UNIT_BIT];
      assign ci.fault_reaction = fr_w;
      assign ci.on_dly       = ton_q[g];
      assign ci.off_dly      = deenergise_delay_q[g];
      assign ci.remote_state = rem_q[g];
      assign ci.link_fault   = link_fault;
      assign relay_w[g]      = ci.relay;
      assign pend_w[g]       = ci.pending;

      relay_channel u_ch
      (
         .ref_clk    (ref_clk),
         .rst        (rst),
         .tenth_sec  (tenth_sec),
         .tenth_min  (tenth_min),
         .value      (value),
         .over_range (over_range),
         .c          (ci.chan)
      );
   end

   assign relay_out = relay_w;
   assign led_out   = relay_w;
endmodule
`default_nettype wire

// ---- relay_pkg.sv ----
// Purpose: Shared constants and types for the relay threshold controller.
// Assumes: 100 MHz ref_clk, signed 16-bit measurement values.
// Notes:   Register offsets are word indices on the plain register port.
package relay_pkg;

   // Channel count and value widths.
   localparam int          NUM_CH       = 4;
   localparam int          VAL_W        = 16;
   localparam int          DLY_W        = 10;
   localparam int          ADDR_W       = 6;

   // Legal ranges of the settings.
   localparam logic signed [15:0] THR_MIN = -16'sd999;
   localparam logic signed [15:0] THR_MAX = 16'sd9999;
   localparam logic        [15:0] HYS_MAX = 16'd999;
   localparam logic        [9:0]  DLY_MAX = 10'd999;

   // Time base: one tenth of a second, and sixty of those per tenth of a minute.
   localparam int          CLK_HZ          = 100_000_000;
   localparam int          TENTH_SEC_MS    = 100;
   localparam int          TENTH_CYCLES    = CLK_HZ / 1000 * TENTH_SEC_MS;
   localparam logic [5:0]  MIN_PRESCALE    = 6'd59;

   // Per-channel register block: base = ch * CH_STRIDE.
   localparam logic [5:0]  CH_STRIDE       = 6'h08;
   localparam logic [2:0]  OFS_THR1        = 3'h0;
   localparam logic [2:0]  OFS_THR2        = 3'h1;
   localparam logic [2:0]  OFS_HYS         = 3'h2;
   localparam logic [2:0]  OFS_CFG         = 3'h3;
   localparam logic [2:0]  OFS_TON         = 3'h4;
   localparam logic [2:0]  OFS_DEENERGISE_DELAY        = 3'h5;
   localparam logic [2:0]  OFS_REMOTE      = 3'h6;
   localparam logic [2:0]  OFS_STATUS      = 3'h7;
   // Global registers above the channel blocks.
   localparam logic [5:0]  OFS_LINK_LIMIT  = 6'h20;
   localparam logic [5:0]  OFS_LINK_KICK   = 6'h21;

   // Config register fields.
   localparam int          CFG_MODE_LSB    = 0;
   localparam int          CFG_UNIT_BIT    = 3;
   localparam int          CFG_FAULT_LSB   = 4;

   // Reset values.
   localparam logic [15:0] RST_THR         = 16'h0000;
   localparam logic [15:0] RST_HYS         = 16'h0000;
   localparam logic [9:0]  RST_DLY         = 10'h000;
   localparam logic [15:0] RST_LINK_LIMIT  = 16'h0064;

   typedef enum logic [2:0]
   {
      MODE_INACTIVE = 3'h0,
      MODE_ON_ABOVE = 3'h1,
      MODE_OFF_ABOVE = 3'h2,
      MODE_INSIDE   = 3'h3,
      MODE_OUTSIDE  = 3'h4,
      MODE_REMOTE   = 3'h5
   } mode_t;

   typedef enum logic [1:0]
   {
      FAULT_HOLD = 2'h0,
      FAULT_ON   = 2'h1,
      FAULT_OFF  = 2'h2
   } fault_reaction_t;

endpackage

// ---- chan_if.sv ----
// Purpose: Bundle of one channel's settings and results between top and channel.
// Assumes: Driven from the top's register file.
// Notes:   One instance per channel.
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
   import relay_pkg::*;
   logic signed [15:0] thr1;
   logic signed [15:0] thr2;
   logic        [15:0] hys;
   mode_t              mode;
   logic               unit_min;
   fault_reaction_t    fault_reaction;
   logic        [9:0]  on_dly;
   logic        [9:0]  off_dly;
   logic               remote_state;
   logic               link_fault;
   logic               relay;
   logic               pending;

   modport cfg (output thr1, thr2, hys, mode, unit_min, fault_reaction, on_dly, off_dly,
                remote_state, link_fault, input relay, pending);
   modport chan (input thr1, thr2, hys, mode, unit_min, fault_reaction, on_dly, off_dly,
                 remote_state, link_fault, output relay, pending);
endinterface
`default_nettype wire

// ---- relay_channel.sv ----
// Purpose: One relay channel: band compare, qualification delay, fault reaction.
// Assumes: tenth_sec and tenth_min are one-cycle ticks from the shared time base.
// Notes:   Inputs beyond the band in a given direction restart nothing; return inside clears.
`timescale 1ns/1ps
`default_nettype none
module relay_channel
(
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Time base ticks.
   input  wire logic        tenth_sec,
   input  wire logic        tenth_min,
   // Measurement.
   input  wire logic signed [15:0] value,
   input  wire logic        over_range,
   // Settings and results.
   chan_if.chan             c
);
   import relay_pkg::*;

   // Lower and higher thresholds, order free.
   wire logic signed [15:0] lo_thr = (c.thr1 < c.thr2) ? c.thr1 : c.thr2;
   wire logic signed [15:0] hi_thr = (c.thr1 < c.thr2) ? c.thr2 : c.thr1;
   wire logic signed [16:0] hys_s  = {1'b0, c.hys};
   wire logic signed [16:0] v      = 17'(value);
   wire logic signed [16:0] t1_up  = 17'(c.thr1) + hys_s;
   wire logic signed [16:0] t1_dn  = 17'(c.thr1) - hys_s;
   wire logic signed [16:0] lo_up  = 17'(lo_thr) + hys_s;
   wire logic signed [16:0] lo_dn  = 17'(lo_thr) - hys_s;
   wire logic signed [16:0] hi_up  = 17'(hi_thr) + hys_s;
   wire logic signed [16:0] hi_dn  = 17'(hi_thr) - hys_s;

   // Wanted on/off zones; neither asserted means inside a dead band.
   logic want_on;
   logic want_off;
   always_comb
   begin
      want_on  = 1'b0;
      want_off = 1'b0;
      unique case (c.mode)
         MODE_ON_ABOVE:
         begin
            want_on  = v > t1_up;
            want_off = v < t1_dn;
         end
         MODE_OFF_ABOVE:
         begin
            want_off = v > t1_up;
            want_on  = v < t1_dn;
         end
         MODE_INSIDE:
         begin
            want_on  = (v > lo_up) && (v < hi_dn);
            want_off = (v < lo_dn) || (v > hi_up);
         end
         MODE_OUTSIDE:
         begin
            want_on  = (v > hi_up) || (v < lo_dn);
            want_off = (v > lo_up) && (v < hi_dn);
         end
         default:
         begin
            want_on  = 1'b0;
            want_off = 1'b0;
         end
      endcase
   end

   // Relay state and qualification counter.
   logic       relay_q;
   logic       relay_d;
   logic [9:0] cnt_q;
   logic [9:0] cnt_d;

   // Critical condition per mode family; range faults count in inactive mode too, so forced-on can act.
   wire logic range_mode = c.mode != MODE_REMOTE;
   wire logic critical = (range_mode && over_range)
                         || ((c.mode == MODE_REMOTE) && c.link_fault);
   wire logic tick     = c.unit_min ? tenth_min : tenth_sec;
   wire logic pursue   = relay_q ? want_off : want_on;
   wire logic [9:0] lim = relay_q ? c.off_dly : c.on_dly;

   // Next state: forced-on first, then inactive, other fault reactions, remote, qualified thresholds.
   always_comb
   begin
      relay_d = relay_q;
      cnt_d   = cnt_q;
      if (critical && c.fault_reaction == FAULT_ON)
      begin
         relay_d = 1'b1;
         cnt_d   = '0;
      end
      else if (c.mode == MODE_INACTIVE)
      begin
         relay_d = 1'b0;
         cnt_d   = '0;
      end
      else if (critical && c.fault_reaction == FAULT_OFF)
      begin
         relay_d = 1'b0;
         cnt_d   = '0;
      end
      else if (critical)
         cnt_d   = '0;                                   // Hold state.
      else if (c.mode == MODE_REMOTE)
      begin
         relay_d = c.remote_state;
         cnt_d   = '0;
      end
      else if (!pursue)
         cnt_d   = '0;
      else if (cnt_q >= lim)
      begin
         relay_d = !relay_q;
         cnt_d   = '0;
      end
      else if (tick)
         cnt_d   = cnt_q + 10'd1;
   end

   // Relay and delay counter registers.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         relay_q <= 1'b0;
         cnt_q   <= '0;
      end
      else
      begin
         relay_q <= relay_d;
         cnt_q   <= cnt_d;
      end
   end

   assign c.relay   = relay_q;
   assign c.pending = cnt_q != 10'd0;
endmodule
`default_nettype wire

// ---- relay_ctrl_sva.sv ----
// Purpose: Port-level checker for the relay controller.
// Assumes: Channel 0 configuration is mirrored by snooping register writes.
// Notes:   The mirror cannot see the link timer, so remote mode is left to the bench.
`timescale 1ns/1ps
`default_nettype none
module relay_ctrl_sva
(
   // Clock and reset.
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   // Measurement and link.
   input  wire logic signed [15:0]           value,
   input  wire logic                         over_range,
   input  wire logic                         link_rx,
   // Register port.
   input  wire logic [5:0]                   reg_addr,
   input  wire logic [15:0]                  reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   input  wire logic [15:0]                  reg_rdata,
   // Outputs.
   input  wire logic [relay_pkg::NUM_CH-1:0] relay_out,
   input  wire logic [relay_pkg::NUM_CH-1:0] led_out
);
   import relay_pkg::*;
   logic [2:0] mode_q;
   logic [1:0] fault_q;
   logic       cfg_wr;
   logic       thr_mode;
   logic       idle_mode;

   // Decode of the channel 0 configuration write and mode classes.
   assign cfg_wr    = reg_wr && (reg_addr == {3'h0, OFS_CFG});
   assign thr_mode  = (mode_q >= 3'h1) && (mode_q <= 3'h4);
   assign idle_mode = (mode_q == 3'h0) || (mode_q > 3'h5);

   // Mirror of channel 0 mode and fault reaction; cleared with the design's settings.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         mode_q  <= 3'h0;
         fault_q <= 2'h0;
      end
      else if (cfg_wr)
      begin
         mode_q  <= reg_wdata[2:0];
         fault_q <= reg_wdata[5:4];
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_led_tracks_relay: assert property (led_out == relay_out)
      else $error("led differs from relay");
   a_reset_clears_relay: assert property (disable iff (1'b0) rst |=> relay_out == 4'h0)
      else $error("relay not cleared by reset");
   a_inactive_stays_off: assert property ((idle_mode && !over_range) [*2] |-> !relay_out[0])
      else $error("inactive channel drives relay");
   a_forced_on_wins: assert property (
      (fault_q == 2'h1 && over_range && mode_q != 3'h5) [*2] |-> relay_out[0])
      else $error("forced on not applied");
   a_forced_off_wins: assert property (
      (fault_q == 2'h2 && over_range && mode_q != 3'h5) [*2] |-> !relay_out[0])
      else $error("forced off not applied");
   a_hold_freezes: assert property (
      (fault_q[0] == fault_q[1] && over_range && thr_mode) [*3] |-> $stable(relay_out[0]))
      else $error("held relay changed");
   a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   a_unmapped_zero: assert property (reg_rd && reg_addr > OFS_LINK_KICK |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");

   // Main scenarios seen by the bench.
   c_remote_on: cover property (mode_q == 3'h5 && relay_out[0]);
   c_forced_on: cover property (idle_mode && relay_out[0]);
   c_unmapped: cover property (reg_rd && reg_addr > OFS_LINK_KICK);
endmodule
bind relay_ctrl relay_ctrl_sva i_relay_ctrl_sva (.ref_clk(ref_clk), .rst(rst), .value(value),
   .over_range(over_range), .link_rx(link_rx), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .relay_out(relay_out), .led_out(led_out));
`default_nettype wire

// ---- relay_load_model.sv ----
// Purpose: Far side model: relay driver, panel LEDs and the remote link master.
// Assumes: One frame request from the bench yields one link pulse.
// Notes:   A LED that ever disagrees with its relay is latched for the bench.
`timescale 1ns/1ps
`default_nettype none
module relay_load_model
(
   // Clock and reset.
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   // Driven loads.
   input  wire logic [relay_pkg::NUM_CH-1:0] relay_out,
   input  wire logic [relay_pkg::NUM_CH-1:0] led_out,
   // Link side.
   input  wire logic                         frame_req,
   output logic                              link_rx,
   output logic                              led_bad
);
   import relay_pkg::*;

   // Frames are single-cycle pulses; a held request gives one pulse every second cycle.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         link_rx <= 1'b0;
         led_bad <= 1'b0;
      end
      else
      begin
         link_rx <= frame_req && !link_rx;
         if (led_out !== relay_out)
            led_bad <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- relay_threshold_controller_tb_top.sv ----
// Purpose: Self-checking bench for the relay controller over its register port.
// Assumes: Nonzero delays are only checked to hold the relay, since the tenth-second tick is far beyond the run.
// Notes:   Relay checks wait three cycles after each input change.
`timescale 1ns/1ps
`default_nettype none
module relay_threshold_controller_tb_top;
   import relay_pkg::*;
   logic                     ref_clk = 1'b0;
   logic                     rst = 1'b1;
   logic signed [15:0]       value = 16'sh0000;
   logic                     over_range = 1'b0;
   logic [5:0]               reg_addr = 6'h00;
   logic [15:0]              reg_wdata = 16'h0000;
   logic                     reg_wr = 1'b0;
   logic                     reg_rd = 1'b0;
   logic                     frame_req = 1'b0;
   wire logic [15:0]         reg_rdata;
   wire logic [NUM_CH-1:0]   relay_out;
   wire logic [NUM_CH-1:0]   led_out;
   wire logic                link_rx;
   wire logic                led_bad;
   int                       err_total = 0;
   int                       checked = 0;

   always #5 ref_clk = ~ref_clk;

   relay_ctrl i_relay_ctrl (.ref_clk(ref_clk), .rst(rst), .value(value), .over_range(over_range),
      .link_rx(link_rx), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .relay_out(relay_out), .led_out(led_out));
   relay_load_model i_relay_load_model (.ref_clk(ref_clk), .rst(rst), .relay_out(relay_out),
      .led_out(led_out), .frame_req(frame_req), .link_rx(link_rx), .led_bad(led_bad));

   // Comparison tasks, one per kind of result.
   task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] seen);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic chk4(input string name, input logic [3:0] exp, input logic [3:0] seen);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Register port cycles; a free edge separates calls so strobes never double-assign.
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk16("read data", exp, reg_rdata);
   endtask

   // Applies input and range flag, then checks relays and LEDs once settled.
   task automatic drive(input logic signed [15:0] v, input logic o, input logic [3:0] exp);
      @(posedge ref_clk);
      value <= v;
      over_range <= o;
      repeat (3) @(posedge ref_clk);
      #1;
      chk4("relay", exp, relay_out);
      chk4("led", exp, led_out);
   endtask

   function automatic logic [15:0] cfgv(input logic [2:0] m, input logic [1:0] f);
      return {10'h000, f, 1'b0, m};
   endfunction

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog: the sequence needs well under two thousand cycles.
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      give_verdict();
   end

   initial
   begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rd(6'h00, 16'h0000);
      rd(OFS_LINK_LIMIT, RST_LINK_LIMIT);
      rd(6'h22, 16'h0000);
      wr(6'h07, 16'hffff);
      rd(6'h07, 16'h0000);
      $display("test reset_values done");
      wr(6'h00, 16'h2710);
      rd(6'h00, 16'h270f);
      wr(6'h01, 16'hfc18);
      rd(6'h01, 16'hfc19);
      wr(6'h02, 16'h03e8);
      rd(6'h02, 16'h03e7);
      $display("test clamping done");
      wr(6'h00, 16'h0064);
      wr(6'h02, 16'h000a);
      wr(6'h03, cfgv(MODE_ON_ABOVE, FAULT_HOLD));
      drive(16'sd105, 1'b0, 4'h0);
      drive(16'sd110, 1'b0, 4'h0);
      drive(16'sd111, 1'b0, 4'h1);
      drive(16'sd95, 1'b0, 4'h1);
      drive(16'sd89, 1'b0, 4'h0);
      wr(6'h03, cfgv(MODE_OFF_ABOVE, FAULT_HOLD));
      drive(16'sd89, 1'b0, 4'h1);
      drive(16'sd111, 1'b0, 4'h0);
      $display("test single_threshold done");
      wr(6'h00, 16'h012c);
      wr(6'h01, 16'h0064);
      wr(6'h03, cfgv(MODE_INSIDE, FAULT_HOLD));
      drive(16'sd200, 1'b0, 4'h1);
      drive(16'sd295, 1'b0, 4'h1);
      drive(16'sd311, 1'b0, 4'h0);
      drive(16'sd200, 1'b0, 4'h1);
      wr(6'h03, cfgv(MODE_OUTSIDE, FAULT_HOLD));
      drive(16'sd200, 1'b0, 4'h0);
      drive(16'sd320, 1'b0, 4'h1);
      drive(16'sd200, 1'b0, 4'h0);
      drive(16'sd80, 1'b0, 4'h1);
      drive(16'sd105, 1'b0, 4'h1);
      $display("test two_thresholds done");
      wr(6'h03, cfgv(MODE_ON_ABOVE, FAULT_OFF));
      drive(16'sd400, 1'b0, 4'h1);
      drive(16'sd400, 1'b1, 4'h0);
      wr(6'h03, cfgv(MODE_ON_ABOVE, FAULT_HOLD));
      drive(16'sd400, 1'b1, 4'h0);
      drive(16'sd400, 1'b0, 4'h1);
      drive(16'sd0, 1'b1, 4'h1);
      wr(6'h03, cfgv(MODE_INACTIVE, FAULT_ON));
      drive(16'sd0, 1'b1, 4'h1);
      drive(16'sd400, 1'b0, 4'h0);
      $display("test fault_reaction done");
      wr(6'h03, cfgv(MODE_REMOTE, FAULT_HOLD));
      wr(6'h06, 16'h0001);
      drive(16'sd0, 1'b0, 4'h1);
      wr(6'h06, 16'h0000);
      drive(16'sd400, 1'b1, 4'h0);
      @(posedge ref_clk);
      frame_req <= 1'b1;
      @(posedge ref_clk);
      frame_req <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rd(OFS_LINK_KICK, 16'h0000);
      wr(6'h06, 16'h0001);
      drive(16'sd0, 1'b0, 4'h1);
      chk4("led fault", 4'h0, {3'h0, led_bad});
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk4("relay", 4'h0, relay_out);
      rd(6'h06, 16'h0000);
      $display("test remote done");
      wr(6'h08, 16'h0032);
      wr(6'h0b, cfgv(MODE_ON_ABOVE, FAULT_HOLD));
      wr(6'h03, cfgv(MODE_ON_ABOVE, FAULT_HOLD));
      drive(16'sd100, 1'b0, 4'h3);
      drive(16'sd20, 1'b0, 4'h1);
      wr(6'h0c, 16'h0005);
      wr(6'h05, 16'h0005);
      drive(16'sd100, 1'b0, 4'h1);
      drive(-16'sd20, 1'b0, 4'h1);
      wr(6'h0b, 16'h0009);
      rd(6'h0b, 16'h0009);
      chk4("led fault", 4'h0, {3'h0, led_bad});
      $display("test channels done");
      give_verdict();
   end
endmodule
`default_nettype wire
